// ---- rtl/flow_out_pkg.sv ----
package flow_out_pkg;

	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned PW_RST_MS = 1;
	localparam logic [31:0] PW_RST = 32'(PW_RST_MS * CLK_HZ / 1000);

	// register byte addresses
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_AMOUNT = 8'h04;
	localparam logic [7:0] A_PWIDTH = 8'h08;
	localparam logic [7:0] A_FLOW = 8'h0c;
	localparam logic [7:0] A_FHIGH = 8'h10;
	localparam logic [7:0] A_RLOW = 8'h14;
	localparam logic [7:0] A_RHIGH = 8'h18;
	localparam logic [7:0] A_ITEMS = 8'h1c;
	localparam logic [7:0] A_WARN = 8'h20;
	localparam logic [7:0] A_FSVAL = 8'h24;
	localparam logic [7:0] A_TOTAL = 8'h28;
	localparam logic [7:0] A_STAT = 8'h2c;
	localparam logic [7:0] A_IRQ_ST = 8'h30;
	localparam logic [7:0] A_IRQ_CLR = 8'h34;
	localparam logic [7:0] A_IRQ_EN = 8'h38;

	// reset values and loop fail-safe current levels in microamps
	localparam logic [31:0] CTRL_RST = 32'h0000_00c0;
	localparam logic [31:0] AMOUNT_RST = 32'h0000_0100;
	localparam logic [31:0] RHIGH_RST = 32'h0000_0001;
	localparam logic [15:0] LOOP_LOWER_UA = 16'h0e10;
	localparam logic [15:0] LOOP_UPPER_UA = 16'h5208;
	localparam logic [15:0] LOOP_MAX_UA = 16'h61a8;

	// interrupt and alarm item bit positions
	localparam int unsigned IRQ_W = 5;
	localparam int unsigned IRQ_PULSE = 0;
	localparam int unsigned IRQ_TRST = 1;
	localparam int unsigned IRQ_PAUSE = 2;
	localparam int unsigned IRQ_LFAIL = 3;
	localparam int unsigned IRQ_WARN = 4;
	localparam int unsigned ITEM_WARN = 0;

	typedef enum logic [2:0] {
		FS_LOWER = 3'h0,
		FS_UPPER = 3'h1,
		FS_LAST = 3'h2,
		FS_ACTUAL = 3'h3,
		FS_FIXED = 3'h4
	} fs_sel_t;

	typedef enum logic [1:0] {
		DIV_IDLE = 2'b00,
		DIV_RUN = 2'b01,
		DIV_DONE = 2'b11
	} div_state_t;

	typedef struct packed {
		logic [21:0] rsvd;
		logic [1:0] cls;
		logic pol8;
		logic pol7;
		fs_sel_t fs;
		logic route;
		logic by_item;
		logic freq_mode;
	} ctrl_t;

	typedef struct packed {
		logic valid;
		logic signed [31:0] flow;
		logic signed [31:0] pv;
		logic [15:0] loop_ua;
	} meas_t;

endpackage

// ---- rtl/pulse_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module pulse_timer #(
	parameter int W = 32
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// request
	input wire logic start_i,
	input wire logic [W-1:0] width_i,
	// pulse
	output logic pulse_o,
	output logic busy_o
);

	typedef struct packed {
		logic out;
		logic [W-1:0] left;
	} pt_t;

	pt_t s_reg;
	pt_t s_next;
	logic [W-1:0] len_q;
	logic [W-1:0] w_q;

	always_comb
	begin
		s_next = s_reg;
		if (!s_reg.out)
		begin
			// a width of zero emits nothing
			if (start_i && width_i != '0)
			begin
				s_next.out = 1'b1;
				s_next.left = width_i - 1'b1; // see RQ2
			end
		end
		else if (s_reg.left == '0)
			s_next.out = 1'b0;
		else
			s_next.left = s_reg.left - 1'b1;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign pulse_o = s_reg.out;
	assign busy_o = s_reg.out;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			len_q <= '0;
			w_q <= '0;
		end
		else
		begin
			len_q <= s_reg.out ? len_q + 1'b1 : '0;
			if (!s_reg.out && start_i)
				w_q <= width_i;
		end
	end

	property p_pulse_len;
		@(posedge clk_i) disable iff (!rst_n_i)
		$fell(s_reg.out) |-> len_q == w_q;
	endproperty
	a_pulse_len: assert property (p_pulse_len) // see RQ2
		else $error("pulse width differs from the configured width");

endmodule
`default_nettype wire

// ---- rtl/ratio_divider.sv ----
`timescale 1ns/1ps
`default_nettype none
module ratio_divider
	import flow_out_pkg::*;
#(
	parameter int W = 32
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// operands
	input wire logic start_i,
	input wire logic [2*W-1:0] num_i,
	input wire logic [W-1:0] den_i,
	// result
	output logic busy_o,
	output logic done_o,
	output logic [W-1:0] quo_o
);

	localparam int CW = $clog2(2 * W);

	typedef struct packed {
		div_state_t st;
		logic [W:0] rem;
		logic [2*W-1:0] q;
		logic [W-1:0] den;
		logic [CW-1:0] cnt;
	} dv_t;

	dv_t s_reg;
	dv_t s_next;
	logic [W:0] trial;

	always_comb
	begin
		s_next = s_reg;
		trial = {s_reg.rem[W-1:0], s_reg.q[2*W-1]};
		unique case (s_reg.st)
			DIV_IDLE:
			if (start_i)
			begin
				s_next.st = DIV_RUN;
				s_next.rem = '0;
				s_next.q = num_i;
				s_next.den = den_i;
				s_next.cnt = CW'(2 * W - 1);
			end
			DIV_RUN:
			begin
				// restoring division, one quotient bit per clock
				s_next.q = {s_reg.q[2*W-2:0], 1'b0};
				if (trial >= {1'b0, s_reg.den})
				begin
					s_next.rem = trial - {1'b0, s_reg.den};
					s_next.q[0] = 1'b1;
				end
				else
					s_next.rem = trial;
				s_next.cnt = s_reg.cnt - 1'b1;
				if (s_reg.cnt == '0)
					s_next.st = DIV_DONE;
			end
			DIV_DONE:
				s_next.st = DIV_IDLE;
			default:
				s_next.st = DIV_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign busy_o = s_reg.st != DIV_IDLE;
	assign done_o = s_reg.st == DIV_DONE;
	assign quo_o = s_reg.q[W-1:0];

	property p_ratio;
		@(posedge clk_i) disable iff (!rst_n_i)
		(s_reg.st == DIV_IDLE && start_i && den_i != '0)
			|-> ##(2 * W + 1) done_o && s_reg.q <= $past(num_i, 2 * W + 1);
	endproperty
	a_ratio: assert property (p_ratio) // see RQ6
		else $error("scaling division not finished on time");

endmodule
`default_nettype wire

// ---- rtl/flow_pulse_frequency_output.sv ----
// Behaviour
// RQ1 - pulse mode: one pulse each time accumulated quantity reaches amount per pulse
// RQ2 - each pulse lasts the configured width; rate follows the measured flow
// RQ3 - pulse start spacing equals amount per pulse over measured flow
// RQ4 - software picks a width leaving off time above width at top flow
// RQ5 - frequency mode: 50% duty square wave proportional to the process value
// RQ6 - frequency maps lower..upper range linearly onto low..high frequency
// RQ7 - attached equipment must register every frequency in the band
// RQ8 - alarm status goes either to the status output or to the relay
// RQ9 - class mode: output set while any alarm of the selected class is active
// RQ10 - item mode: output set while any of several selected items is active
// RQ11 - process value below warning limit raises a warning; limit 0 flags negative
// RQ12 - loop failure drives lower, upper, last, actual or fixed fail-safe value
// RQ13 - active digital input 7 resets totalizer, input 8 toggles its pause
// RQ14 - changing an input's polarity runs that input's function once
// RQ15 - frequency clamps to low below lower range, high above upper range
//
// The register offsets and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module flow_pulse_frequency_output
	import flow_out_pkg::*;
#(
	parameter logic [15:0] LOOP_LOWER = LOOP_LOWER_UA,
	parameter logic [15:0] LOOP_UPPER = LOOP_UPPER_UA
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// avalon-mm slave
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// measurement core
	input wire meas_t meas_i,
	input wire logic [31:0] alarm_item_i,
	input wire logic [3:0] alarm_class_i,
	input wire logic loop_fail_i,
	// digital input pins
	input wire logic din7_i,
	input wire logic din8_i,
	// outputs
	output logic pulse_freq_o,
	output logic status_o,
	output logic relay_o,
	output logic [15:0] loop_ua_o,
	output logic irq_o
);

	typedef struct packed {
		ctrl_t ctrl;
		logic [31:0] amount;
		logic [31:0] pwidth;
		logic [31:0] flo;
		logic [31:0] fhi;
		logic signed [31:0] rlo;
		logic signed [31:0] rhi;
		logic [31:0] items;
		logic signed [31:0] warn;
		logic [15:0] fsval;
		logic signed [31:0] total;
		logic paused;
		logic signed [32:0] acc;
		logic [31:0] phase;
		logic [31:0] inc;
		logic [IRQ_W-1:0] irq_st;
		logic [IRQ_W-1:0] irq_en;
		logic wait_q;
		logic [31:0] rdata;
		logic [1:0] s7;
		logic [1:0] s8;
		logic act7;
		logic act8;
		logic pol7_q;
		logic pol8_q;
		logic warn_q;
		logic fail_q;
		logic [15:0] last_ua;
		logic [15:0] loop_ua;
		logic status;
		logic relay;
		logic pf;
		logic irq;
	} st_t;

	function automatic logic [31:0] be_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[8*i +: 8] = wd[8*i +: 8];
		return r;
	endfunction

	st_t s;
	st_t n;
	logic [1:0] rs;
	logic rst_n_q;
	logic p_out;
	logic p_busy;
	logic p_start;
	logic d_busy;
	logic d_done;
	logic d_start;
	logic [31:0] d_quo;
	logic signed [31:0] pvc;
	logic [31:0] diff;
	logic [63:0] num;
	logic [31:0] rd;
	logic [31:0] clr;
	logic [31:0] items_eff;
	logic [IRQ_W-1:0] ev;
	logic ev7;
	logic ev8;
	logic sel;
	logic signed [32:0] acc_t;

	// the async reset is released in step with the clock
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rs <= 2'b00;
		else
			rs <= {rs[0], 1'b1};
	end
	assign rst_n_q = rs[1];

	pulse_timer #(
		.W(32)
	) u_pulse (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n_q),
		.start_i(p_start),
		.width_i(s.pwidth),
		.pulse_o(p_out),
		.busy_o(p_busy)
	);

	ratio_divider #(
		.W(32)
	) u_div (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n_q),
		.start_i(d_start),
		.num_i(num),
		.den_i(32'(s.rhi - s.rlo)),
		.busy_o(d_busy),
		.done_o(d_done),
		.quo_o(d_quo)
	);

	always_comb
	begin
		n = s;
		rd = 32'h0000_0000;
		clr = 32'h0000_0000;
		ev = '0;

		// register reads are answered one cycle after the request
		unique case (avs_address_i)
			A_CTRL: rd = s.ctrl;
			A_AMOUNT: rd = s.amount;
			A_PWIDTH: rd = s.pwidth;
			A_FLOW: rd = s.flo;
			A_FHIGH: rd = s.fhi;
			A_RLOW: rd = s.rlo;
			A_RHIGH: rd = s.rhi;
			A_ITEMS: rd = s.items;
			A_WARN: rd = s.warn;
			A_FSVAL: rd = {16'h0000, s.fsval};
			A_TOTAL: rd = s.total;
			A_STAT: rd = {27'h0000000, s.paused, s.warn_q, s.fail_q,
				s.status | s.relay, s.pf};
			A_IRQ_ST: rd = {27'h0000000, s.irq_st};
			A_IRQ_EN: rd = {27'h0000000, s.irq_en};
			default: rd = 32'h0000_0000;
		endcase
		n.wait_q = 1'b1;
		if ((avs_read_i || avs_write_i) && s.wait_q)
		begin
			n.wait_q = 1'b0;
			n.rdata = avs_read_i ? rd : 32'h0000_0000;
		end
		if (avs_write_i && !s.wait_q)
		begin
			unique case (avs_address_i)
				A_CTRL:
				begin
					n.ctrl = ctrl_t'(be_merge(s.ctrl, avs_writedata_i,
						avs_byteenable_i));
					n.ctrl.rsvd = '0;
				end
				A_AMOUNT: n.amount = be_merge(s.amount, avs_writedata_i,
					avs_byteenable_i);
				A_PWIDTH: n.pwidth = be_merge(s.pwidth, avs_writedata_i,
					avs_byteenable_i);
				A_FLOW: n.flo = be_merge(s.flo, avs_writedata_i,
					avs_byteenable_i);
				A_FHIGH: n.fhi = be_merge(s.fhi, avs_writedata_i,
					avs_byteenable_i);
				A_RLOW: n.rlo = be_merge(s.rlo, avs_writedata_i,
					avs_byteenable_i);
				A_RHIGH: n.rhi = be_merge(s.rhi, avs_writedata_i,
					avs_byteenable_i);
				A_ITEMS: n.items = be_merge(s.items, avs_writedata_i,
					avs_byteenable_i);
				A_WARN: n.warn = be_merge(s.warn, avs_writedata_i,
					avs_byteenable_i);
				A_FSVAL: n.fsval = 16'(be_merge({16'h0000, s.fsval},
					avs_writedata_i, avs_byteenable_i));
				A_IRQ_CLR: clr = be_merge(32'h0000_0000, avs_writedata_i,
					avs_byteenable_i);
				A_IRQ_EN: n.irq_en = IRQ_W'(be_merge({27'h0000000,
					s.irq_en}, avs_writedata_i, avs_byteenable_i));
				default: n.irq_en = s.irq_en;
			endcase
		end

		// digital inputs; any polarity change also fires the function
		n.s7 = {s.s7[0], din7_i};
		n.s8 = {s.s8[0], din8_i};
		n.act7 = s.s7[1] ~^ s.ctrl.pol7;
		n.act8 = s.s8[1] ~^ s.ctrl.pol8;
		n.pol7_q = s.ctrl.pol7;
		n.pol8_q = s.ctrl.pol8;
		ev7 = (n.act7 && !s.act7) || (s.ctrl.pol7 != s.pol7_q); // see RQ14
		ev8 = (n.act8 && !s.act8) || (s.ctrl.pol8 != s.pol8_q); // see RQ14

		// totalizer 1; reset has priority over a new sample
		if (meas_i.valid && !s.paused)
			n.total = s.total + meas_i.flow;
		if (ev7)
			n.total = 32'sh0000_0000; // see RQ13
		if (ev8)
			n.paused = !s.paused; // see RQ13

		// pulse mode: overdue quantity waits while a pulse is running
		p_start = !s.ctrl.freq_mode && !p_busy
			&& s.acc >= $signed({1'b0, s.amount}); // see RQ1
		acc_t = s.acc + (meas_i.valid ? 33'(meas_i.flow) : 33'sh0);
		if (p_start)
			acc_t = acc_t - $signed({1'b0, s.amount}); // see RQ3
		n.acc = s.ctrl.freq_mode ? 33'sh0 : acc_t;

		// frequency mode: phase msb gives an even duty cycle
		pvc = meas_i.pv < s.rlo ? s.rlo
			: (meas_i.pv > s.rhi ? s.rhi : meas_i.pv); // see RQ15
		diff = 32'(pvc - s.rlo);
		num = 64'(diff) * 64'(32'(s.fhi - s.flo)); // see RQ6
		d_start = s.ctrl.freq_mode && meas_i.valid && !d_busy;
		if (d_done)
			n.inc = s.flo + d_quo; // see RQ6
		n.phase = s.ctrl.freq_mode ? s.phase + s.inc : 32'h0000_0000;
		n.pf = s.ctrl.freq_mode ? s.phase[31] : p_out; // see RQ5

		// warning against the lower limit of the process value
		if (meas_i.valid)
			n.warn_q = meas_i.pv < s.warn; // see RQ11

		// alarm status and its routing
		items_eff = alarm_item_i;
		items_eff[ITEM_WARN] = alarm_item_i[ITEM_WARN] | s.warn_q;
		sel = s.ctrl.by_item ? |(items_eff & s.items) // see RQ10
			: alarm_class_i[s.ctrl.cls]; // see RQ9
		n.status = sel && !s.ctrl.route; // see RQ8
		n.relay = sel && s.ctrl.route; // see RQ8

		// loop fail-safe source
		n.fail_q = loop_fail_i;
		if (!loop_fail_i)
			n.last_ua = meas_i.loop_ua;
		if (!loop_fail_i)
			n.loop_ua = meas_i.loop_ua;
		else
		begin
			unique case (s.ctrl.fs)
				FS_UPPER: n.loop_ua = LOOP_UPPER; // see RQ12
				FS_LAST: n.loop_ua = s.last_ua; // see RQ12
				FS_ACTUAL: n.loop_ua = meas_i.loop_ua; // see RQ12
				FS_FIXED: n.loop_ua = s.fsval > LOOP_MAX_UA
					? LOOP_MAX_UA : s.fsval; // see RQ12
				default: n.loop_ua = LOOP_LOWER; // see RQ12
			endcase
		end

		// sticky events; a new event beats a clear in the same cycle
		ev[IRQ_PULSE] = p_start;
		ev[IRQ_TRST] = ev7;
		ev[IRQ_PAUSE] = ev8;
		ev[IRQ_LFAIL] = loop_fail_i && !s.fail_q;
		ev[IRQ_WARN] = n.warn_q && !s.warn_q;
		n.irq_st = (s.irq_st & ~clr[IRQ_W-1:0]) | ev;
		n.irq = |(n.irq_st & n.irq_en);
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			s <= '0;
			s.ctrl <= CTRL_RST;
			s.pol7_q <= CTRL_RST[6];
			s.pol8_q <= CTRL_RST[7];
			s.amount <= AMOUNT_RST;
			s.pwidth <= PW_RST;
			s.rhi <= RHIGH_RST;
			s.wait_q <= 1'b1;
		end
		else
			s <= n;
	end

	assign avs_readdata_o = s.rdata;
	assign avs_waitrequest_o = s.wait_q;
	assign pulse_freq_o = s.pf;
	assign status_o = s.status;
	assign relay_o = s.relay;
	assign loop_ua_o = s.loop_ua;
	assign irq_o = s.irq;

	property p_emit;
		@(posedge ref_clk_i) disable iff (!rst_n_q)
		p_start |=> p_out ##1 pulse_freq_o;
	endproperty
	a_emit: assert property (p_emit) // see RQ1
		else $error("no pulse after the quantity was reached");

	property p_spacing;
		@(posedge ref_clk_i) disable iff (!rst_n_q)
		(p_start && !meas_i.valid && !s.ctrl.freq_mode)
			|=> s.acc == $past(s.acc) - $signed({1'b0, $past(s.amount)});
	endproperty
	a_spacing: assert property (p_spacing) // see RQ3
		else $error("quantity per pulse not taken from the accumulator");

	property p_duty;
		@(posedge ref_clk_i) disable iff (!rst_n_q)
		(s.ctrl.freq_mode && $stable(s.ctrl.freq_mode))
			|-> pulse_freq_o == $past(s.phase[31]);
	endproperty
	a_duty: assert property (p_duty) // see RQ5
		else $error("frequency output does not follow the phase");

	property p_clamp;
		@(posedge ref_clk_i) disable iff (!rst_n_q)
		d_done |=> s.inc >= $past(s.flo) && s.inc <= $past(s.fhi);
	endproperty
	a_clamp: assert property (p_clamp) // see RQ15
		else $error("frequency increment left the low..high band");

	property p_class;
		@(posedge ref_clk_i) disable iff (!rst_n_q)
		(!s.ctrl.by_item && !s.ctrl.route && alarm_class_i[s.ctrl.cls])
			|=> status_o && !relay_o;
	endproperty
	a_class: assert property (p_class) // see RQ9
		else $error("class alarm not shown on status output");

	property p_item;
		@(posedge ref_clk_i) disable iff (!rst_n_q)
		(s.ctrl.by_item && s.ctrl.route && |(alarm_item_i & s.items))
			|=> relay_o && !status_o;
	endproperty
	a_item: assert property (p_item) // see RQ10
		else $error("selected alarm item not shown on relay output");

	property p_warn;
		@(posedge ref_clk_i) disable iff (!rst_n_q)
		(meas_i.valid && meas_i.pv < s.warn) |=> s.warn_q;
	endproperty
	a_warn: assert property (p_warn) // see RQ11
		else $error("below warning limit not flagged");

	property p_fail;
		@(posedge ref_clk_i) disable iff (!rst_n_q)
		(loop_fail_i && s.ctrl.fs == FS_UPPER) |=> loop_ua_o == LOOP_UPPER;
	endproperty
	a_fail: assert property (p_fail) // see RQ12
		else $error("loop failure not driving the upper fault level");

	property p_pol;
		@(posedge ref_clk_i) disable iff (!rst_n_q)
		(s.ctrl.pol7 != s.pol7_q) |=> s.total == 32'sh0000_0000;
	endproperty
	a_pol: assert property (p_pol) // see RQ14
		else $error("polarity change did not reset the totalizer");

endmodule
`default_nettype wire

// ---- verif/pulse_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
module pulse_counter (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// watched output line
	input wire logic sig_i,
	// last completed high and low phase, in cycles
	output logic [15:0] hi_len_o,
	output logic [15:0] lo_len_o
);
	logic prev_reg;
	logic [15:0] run_reg;
	// every clock is sampled, so each band frequency is seen
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			prev_reg <= 1'b0;
			run_reg <= 16'h0000;
			hi_len_o <= 16'h0000;
			lo_len_o <= 16'h0000;
		end
		else
		begin
			prev_reg <= sig_i;
			if (sig_i != prev_reg)
			begin
				run_reg <= 16'h0001;
				if (prev_reg)
					hi_len_o <= run_reg;
				else
					lo_len_o <= run_reg;
			end
			else
				run_reg <= run_reg + 16'h0001;
		end
	end
endmodule
`default_nettype wire

// ---- verif/test_flow_pulse_frequency_output.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_flow_pulse_frequency_output
	import flow_out_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic wreq;
	meas_t meas = '0;
	logic [31:0] items = 32'h0;
	logic [3:0] classes = 4'h0;
	logic fail = 1'b0;
	logic din7 = 1'b0;
	logic din8 = 1'b0;
	logic pf;
	logic st;
	logic rl;
	logic irq;
	logic [15:0] ua;
	logic [15:0] hi_len;
	logic [15:0] lo_len;
	logic [31:0] q;
	logic [31:0] r;
	logic [31:0] f;
	logic [31:0] m;
	logic [31:0] base;
	logic [15:0] exp_ua[5];
	logic signed [31:0] pvs[4];
	int errors = 0;
	int check_count = 0;
	int k;

	always #20 ref_clk = ~ref_clk;

	flow_pulse_frequency_output i_dut (
		.ref_clk_i(ref_clk), .rst_n_i(rst_n),
		.avs_address_i(addr), .avs_read_i(rd_en), .avs_write_i(wr_en),
		.avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
		.meas_i(meas), .alarm_item_i(items), .alarm_class_i(classes),
		.loop_fail_i(fail), .din7_i(din7), .din8_i(din8),
		.pulse_freq_o(pf), .status_o(st), .relay_o(rl),
		.loop_ua_o(ua), .irq_o(irq)
	);

	pulse_counter i_counter (
		.clk_i(ref_clk), .rst_n_i(rst_n), .sig_i(pf),
		.hi_len_o(hi_len), .lo_len_o(lo_len)
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD t=%0t seen=%h expected=%h", $time, got, exp);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// an active alarm shows on exactly one of the two outputs
	function automatic logic [31:0] route_exp(input logic hit,
		input logic to_relay);
		return {30'h0, hit && !to_relay, hit && to_relay};
	endfunction

	// half period in clocks for the band 2^26..2^27 over range 0..100
	function automatic logic [15:0] exp_half(input logic signed [31:0] pv);
		logic [63:0] c;
		logic [63:0] inc;
		c = pv < 0 ? 64'h0 : (pv > 100 ? 64'd100 : 64'(pv));
		inc = 64'h0400_0000 + c * 64'h0400_0000 / 64'd100;
		return 16'(64'h8000_0000 / inc);
	endfunction

	// request held until waitrequest is sampled low; a dead slave ends the run
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		addr <= a;
		wr_en <= wr;
		rd_en <= !wr;
		wdata <= d;
		for (n = 0; n < 40; n++)
		begin
			@(posedge ref_clk);
			if (wreq === 1'b0)
				break;
		end
		q = rdata;
		rd_en <= 1'b0;
		wr_en <= 1'b0;
		if (n == 40)
		begin
			errors++;
			give_verdict();
		end
		@(posedge ref_clk);
	endtask

	task automatic feed(input logic [31:0] fl, input logic [31:0] p,
		input logic [15:0] u, input int n);
		meas <= '{1'b1, fl, p, u};
		repeat (n) @(posedge ref_clk);
		meas.valid <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask

	task automatic pin(input int which);
		if (which == 7)
			din7 <= 1'b1;
		else
			din8 <= 1'b1;
		repeat (8) @(posedge ref_clk);
		din7 <= 1'b0;
		din8 <= 1'b0;
		repeat (8) @(posedge ref_clk);
	endtask

	initial
	begin
		void'($urandom(32'h9798ea88));
		exp_ua = '{LOOP_LOWER_UA, LOOP_UPPER_UA, 16'h1388, 16'h1b58, 16'h04d2};
		pvs = '{32'sd0, 32'sd100, 32'sd200, -32'sd50};
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		bus(0, A_AMOUNT, 0);
		chk(q, AMOUNT_RST);
		bus(0, A_PWIDTH, 0);
		chk(q, PW_RST);
		bus(0, A_RHIGH, 0);
		chk(q, RHIGH_RST);
		bus(1, 8'h3c, 32'h5a5a_5a5a);
		bus(0, 8'h3c, 0);
		chk(q, 32'h0);
		$display("test registers done");
		// short width keeps stray pulses out of the later tests
		bus(1, A_PWIDTH, 3);
		bus(1, A_IRQ_CLR, 32'h1f);
		bus(1, A_IRQ_EN, 32'h1 << IRQ_TRST);
		pin(7);
		bus(0, A_TOTAL, 0);
		chk(q, 32'h0);
		chk({31'h0, irq}, 32'h1);
		bus(0, A_IRQ_ST, 0);
		chk(q & (32'h1 << IRQ_TRST), 32'h1 << IRQ_TRST);
		bus(1, A_IRQ_EN, 0);
		repeat (2) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h0);
		bus(1, A_IRQ_CLR, 32'h1f);
		feed(7, 10, 16'h0, 10);
		bus(0, A_TOTAL, 0);
		chk(q, 32'd70);
		pin(8);
		bus(0, A_STAT, 0);
		chk(q & 32'h10, 32'h10);
		feed(7, 10, 16'h0, 10);
		bus(0, A_TOTAL, 0);
		chk(q, 32'd70);
		bus(1, A_CTRL, 32'h40);
		repeat (8) @(posedge ref_clk);
		bus(0, A_STAT, 0);
		chk(q & 32'h10, 32'h0);
		feed(7, 10, 16'h0, 10);
		bus(1, A_CTRL, 32'h00);
		repeat (8) @(posedge ref_clk);
		bus(0, A_TOTAL, 0);
		chk(q, 32'h0);
		base = 32'h0;
		$display("test digital inputs done");
		for (k = 0; k < 4; k++)
		begin
			f = 1 + $urandom_range(20);
			// period of at least 8 leaves off time above the width of 3
			m = 8 + $urandom_range(7);
			// a short trip through frequency mode empties the accumulator
			bus(1, A_CTRL, base | 32'h1);
			bus(1, A_CTRL, base);
			bus(1, A_AMOUNT, f * m);
			feed(f, 10, 16'h0, 160);
			chk({16'h0, hi_len}, 32'd3);
			chk(32'(hi_len) + 32'(lo_len), m);
		end
		// corner: overdue quantity drains with no new samples
		bus(1, A_AMOUNT, 1);
		repeat (1500) @(posedge ref_clk);
		chk({16'h0, hi_len}, 32'd3);
		$display("test pulse done");
		bus(1, A_FLOW, 32'h0400_0000);
		bus(1, A_FHIGH, 32'h0800_0000);
		bus(1, A_RLOW, 0);
		bus(1, A_RHIGH, 100);
		bus(1, A_CTRL, base | 32'h1);
		for (k = 0; k < 4; k++)
		begin
			feed(0, pvs[k], 16'h0, 1);
			repeat (400) @(posedge ref_clk);
			chk({16'h0, hi_len}, {16'h0, exp_half(pvs[k])});
			chk({16'h0, lo_len}, {16'h0, exp_half(pvs[k])});
		end
		$display("test frequency done");
		for (k = 0; k < 8; k++)
		begin
			r = $urandom;
			classes <= r[3:0];
			bus(1, A_CTRL, base | (32'(k % 4) << 8) | (32'(k / 4) << 2));
			repeat (3) @(posedge ref_clk);
			chk({30'h0, st, rl}, route_exp(r[k % 4], k >= 4));
		end
		for (k = 0; k < 6; k++)
		begin
			r = $urandom & $urandom & 32'hffff_fffe;
			// the first draw always hits, the first three go to the relay
			items <= (k == 0 ? r : 32'h0) | ($urandom & $urandom & $urandom);
			bus(1, A_ITEMS, r);
			bus(1, A_CTRL, base | 32'h2 | (32'(k < 3) << 2));
			repeat (3) @(posedge ref_clk);
			chk({30'h0, st, rl}, route_exp(|(r & items), k < 3));
		end
		items <= 32'h0;
		bus(1, A_ITEMS, 32'h1);
		bus(1, A_WARN, 0);
		feed(-5, -5, 16'h0, 1);
		chk({31'h0, st}, 32'h1);
		feed(5, 5, 16'h0, 1);
		chk({31'h0, st}, 32'h0);
		$display("test alarms done");
		bus(1, A_FSVAL, 32'h04d2);
		for (k = 0; k < 5; k++)
		begin
			bus(1, A_CTRL, base | (32'(k) << 3));
			fail <= 1'b0;
			feed(0, 5, 16'h1388, 1);
			chk({16'h0, ua}, 32'h1388);
			fail <= 1'b1;
			repeat (3) @(posedge ref_clk);
			feed(0, 5, 16'h1b58, 1);
			chk({16'h0, ua}, {16'h0, exp_ua[k]});
		end
		fail <= 1'b0;
		$display("test fail-safe done");
		give_verdict();
	end
endmodule
`default_nettype wire
